// ==== and_branch_exec_unit.sv ====
// Execution unit for the AND group and the immediate and conditional branches.
// Assumes the sequencer presents one instruction with its operands per issue
// pulse and a classic Wishbone master reaches the special registers.
// Notes on behaviour
// (RULE1) Register AND writes source AND second operand into the destination.
// (RULE2) AND-with-complement inverts the second operand before the AND.
// (RULE3) Record flag set updates first condition field; clear leaves it.
// (RULE4) AND immediate zero-extends the immediate and always records.
// (RULE5) AND immediate shifted puts immediate in upper half and always records.
// (RULE6) Unconditional branch: displacement times four, relative or absolute.
// (RULE7) Conditional branch: displacement times four, relative or absolute.
// (RULE8) Link flag set loads return address with next sequential address.
// (RULE9) Options 16 and 18 decrement counter, branch on non-zero or zero.
// (RULE10) Options 0 and 8: decrement, counter non-zero, bit clear or set.
// (RULE11) Options 2 and 10: decrement, counter zero, bit clear or set.
// (RULE12) Options 4 and 12 test bit clear or set without decrement.
// (RULE13) Select index addresses field n at bit four n plus offset.
// (RULE14) Select index picks the single tested condition bit.
// (RULE15) Test passes if ignore bit set or bit equals sense bit.
// (RULE16) Recording sets sign flags from result, summary from exception register.
// (RULE17) Taken branch presents target; otherwise next address is current plus four.
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "and_branch_defines.svh"

module and_branch_exec_unit
   import and_branch_pkg::*;
#(
   parameter logic [5:0] UNCOND_OPCODE = `OP_UNCOND_BRANCH
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Instruction issue from the sequencer.
   input  wire logic        issue_i,
   input  wire logic [31:0] instr_i,
   input  wire logic [31:0] cia_i,
   input  wire logic [31:0] src_data_i,
   input  wire logic [31:0] opb_data_i,
   // Results towards fetch and the register file.
   output logic             done_o,
   output logic             taken_o,
   output logic             illegal_o,
   output logic      [31:0] nia_o,
   output logic             wr_en_o,
   output logic      [4:0]  wr_idx_o,
   output logic      [31:0] wr_data_o,
   // Classic Wishbone slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o
);

   exec_state_t st_q;
   exec_state_t st_d;
   inst_kind_t  kind;
   logic [5:0]  opcode;
   logic [9:0]  xo;
   logic [4:0]  bo;
   logic [4:0]  bi;
   logic        cond_bit;
   logic [31:0] ctr_next;
   logic        bc_pass;
   logic [31:0] and_res;
   logic [31:0] disp;
   logic [31:0] target;
   logic        record;
   logic        bus_req;
   logic        bus_wr_cond;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   assign opcode = instr_i[`F_OPCODE_HI:`F_OPCODE_LO];
   assign xo     = instr_i[`F_XO_HI:`F_XO_LO];
   assign bo     = instr_i[`F_SRC_HI:`F_SRC_LO];
   assign bi     = instr_i[`F_DEST_HI:`F_DEST_LO];
   // Condition bit 0 is the most significant bit, so field n offset k is bit 4n+k.
   assign cond_bit = st_q.cond[5'd31 - bi]; // [RULE13] [RULE14]

   branch_cond_eval u_cond (
      .bo_i       (bo),
      .cond_bit_i (cond_bit),
      .ctr_i      (st_q.counter),
      .ctr_next_o (ctr_next),
      .pass_o     (bc_pass)
   );

   always_comb begin
      if (opcode == `OP_LOGIC_EXT && xo == `XO_AND) begin
         kind = K_AND;
      end else if (opcode == `OP_LOGIC_EXT && xo == `XO_AND_COMPL) begin
         kind = K_ANDC;
      end else if (opcode == `OP_AND_IMM) begin
         kind = K_ANDI;
      end else if (opcode == `OP_AND_IMM_SHIFT) begin
         kind = K_ANDIS;
      end else if (opcode == UNCOND_OPCODE) begin
         kind = K_BR;
      end else if (opcode == `OP_COND_BRANCH) begin
         kind = K_BC;
      end else begin
         kind = K_ILL;
      end
   end

   assign bus_req     = wb_cyc_i & wb_stb_i & ~st_q.ack;
   assign bus_wr_cond = bus_req & wb_we_i & (wb_adr_i[7:0] == `ADR_COND);

   always_comb begin
      st_d         = st_q;
      st_d.done    = 1'b0;
      st_d.wr_en   = 1'b0;
      st_d.ack     = 1'b0;
      and_res      = `RESET_WORD;
      disp         = `RESET_WORD;
      target       = `RESET_WORD;
      record       = 1'b0;

      // Bus side first, so an instruction in the same cycle overrides it.
      if (bus_req) begin
         st_d.ack = 1'b1;
         if (wb_we_i) begin
            unique case (wb_adr_i[7:0])
               `ADR_COND:      st_d.cond = merge_bytes(st_q.cond, wb_dat_i, wb_sel_i);
               `ADR_RETURN:    st_d.ret_addr = merge_bytes(st_q.ret_addr, wb_dat_i, wb_sel_i);
               `ADR_COUNTER:   st_d.counter = merge_bytes(st_q.counter, wb_dat_i, wb_sel_i);
               `ADR_EXCEPTION: st_d.exception = merge_bytes(st_q.exception, wb_dat_i, wb_sel_i);
               `ADR_STATUS: begin
                  if (wb_sel_i[0] && wb_dat_i[`ST_ILLEGAL_BIT]) begin
                     st_d.illegal = 1'b0;
                  end
               end
               default: st_d.rd_data = st_q.rd_data;
            endcase
         end else begin
            unique case (wb_adr_i[7:0])
               `ADR_COND:      st_d.rd_data = st_q.cond;
               `ADR_RETURN:    st_d.rd_data = st_q.ret_addr;
               `ADR_COUNTER:   st_d.rd_data = st_q.counter;
               `ADR_EXCEPTION: st_d.rd_data = st_q.exception;
               `ADR_STATUS: begin
                  st_d.rd_data = `RESET_WORD;
                  st_d.rd_data[`ST_TAKEN_BIT] = st_q.taken;
                  st_d.rd_data[`ST_ILLEGAL_BIT] = st_q.illegal;
               end
               default: st_d.rd_data = `RESET_WORD;
            endcase
         end
      end

      if (issue_i) begin
         st_d.done   = 1'b1;
         st_d.taken  = 1'b0;
         st_d.nia    = cia_i + `SEQ_STEP; // [RULE17]
         st_d.wr_idx = instr_i[`F_DEST_HI:`F_DEST_LO];
         unique case (kind)
            K_AND: begin
               and_res = src_data_i & opb_data_i; // [RULE1]
               record  = instr_i[`F_RECORD]; // [RULE3]
            end
            K_ANDC: begin
               and_res = src_data_i & ~opb_data_i; // [RULE2]
               record  = instr_i[`F_RECORD]; // [RULE3]
            end
            K_ANDI: begin
               and_res = src_data_i & {16'h0000, instr_i[15:0]}; // [RULE4]
               record  = 1'b1; // [RULE4]
            end
            K_ANDIS: begin
               and_res = src_data_i & {instr_i[15:0], 16'h0000}; // [RULE5]
               record  = 1'b1; // [RULE5]
            end
            K_BR: begin
               disp       = {{6{instr_i[25]}}, instr_i[25:2], 2'b00}; // [RULE6]
               target     = instr_i[`F_ABSOLUTE] ? disp : cia_i + disp; // [RULE6]
               st_d.taken = 1'b1;
               st_d.nia   = target; // [RULE17]
            end
            K_BC: begin
               disp         = {{16{instr_i[15]}}, instr_i[15:2], 2'b00}; // [RULE7]
               target       = instr_i[`F_ABSOLUTE] ? disp : cia_i + disp; // [RULE7]
               st_d.counter = ctr_next; // [RULE9] [RULE10] [RULE11] [RULE12]
               st_d.taken   = bc_pass;
               if (bc_pass) begin
                  st_d.nia = target; // [RULE17]
               end
            end
            K_ILL: begin
               // Unknown opcodes fall through sequentially and raise a sticky flag.
               st_d.illegal = 1'b1;
            end
         endcase
         if (kind == K_AND || kind == K_ANDC || kind == K_ANDI || kind == K_ANDIS) begin
            st_d.wr_en   = 1'b1;
            st_d.wr_data = and_res;
         end
         if (record) begin
            st_d.cond[`CR_NEG_BIT]     = and_res[31]; // [RULE16]
            st_d.cond[`CR_POS_BIT]     = ~and_res[31] & (and_res != `RESET_WORD); // [RULE16]
            st_d.cond[`CR_ZERO_BIT]    = (and_res == `RESET_WORD); // [RULE16]
            st_d.cond[`CR_SUMMARY_BIT] = st_q.exception[`XER_SUMMARY_BIT]; // [RULE16]
         end
         if ((kind == K_BR || kind == K_BC) && instr_i[`F_LINK]) begin
            st_d.ret_addr = cia_i + `SEQ_STEP; // [RULE8]
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign done_o    = st_q.done;
   assign taken_o   = st_q.taken;
   assign illegal_o = st_q.illegal;
   assign nia_o     = st_q.nia;
   assign wr_en_o   = st_q.wr_en;
   assign wr_idx_o  = st_q.wr_idx;
   assign wr_data_o = st_q.wr_data;
   assign wb_dat_o  = st_q.rd_data;
   assign wb_ack_o  = st_q.ack;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   and_result_a: assert property ( // [RULE1]
      issue_i && kind == K_AND |=> wr_en_o && wr_data_o == ($past(src_data_i) & $past(opb_data_i)))
      else $error("register AND result wrong");

   andc_result_a: assert property ( // [RULE2]
      issue_i && kind == K_ANDC |=> wr_data_o == ($past(src_data_i) & ~$past(opb_data_i)))
      else $error("AND with complement result wrong");

   record_hold_a: assert property ( // [RULE3]
      issue_i && (kind == K_AND || kind == K_ANDC) && !instr_i[0] && !bus_wr_cond
      |=> st_q.cond == $past(st_q.cond))
      else $error("condition field changed without record flag");

   andi_result_a: assert property ( // [RULE4]
      issue_i && kind == K_ANDI
      |=> wr_data_o == ($past(src_data_i) & {16'h0000, $past(instr_i[15:0])})
          && st_q.cond[29] == (wr_data_o == 32'h0000_0000))
      else $error("AND immediate result or zero flag wrong");

   andis_result_a: assert property ( // [RULE5]
      issue_i && kind == K_ANDIS
      |=> wr_data_o == ($past(src_data_i) & {$past(instr_i[15:0]), 16'h0000}))
      else $error("AND immediate shifted result wrong");

   summary_copy_a: assert property ( // [RULE16]
      issue_i && kind == K_ANDI |=> st_q.cond[28] == $past(st_q.exception[31]))
      else $error("summary flag not copied");

   link_load_a: assert property ( // [RULE8]
      issue_i && (kind == K_BR || kind == K_BC) && instr_i[0]
      |=> st_q.ret_addr == $past(cia_i) + 32'h0000_0004)
      else $error("return address not loaded");

   ctr_decr_a: assert property ( // [RULE9]
      issue_i && kind == K_BC && !bo[2] |=> st_q.counter == $past(st_q.counter) - 32'h0000_0001)
      else $error("loop counter not decremented");

   ctr_keep_a: assert property ( // [RULE12]
      issue_i && kind == K_BC && bo[2] && !(bus_req && wb_we_i)
      |=> st_q.counter == $past(st_q.counter))
      else $error("loop counter changed without decrement option");

   uncond_nia_a: assert property ( // [RULE6]
      issue_i && kind == K_BR && !instr_i[1]
      |=> taken_o && nia_o == $past(cia_i) + {{6{$past(instr_i[25])}}, $past(instr_i[25:2]), 2'b00})
      else $error("relative branch target wrong");

   seq_nia_a: assert property ( // [RULE17]
      done_o && !taken_o |-> nia_o == $past(cia_i) + 32'h0000_0004)
      else $error("sequential address wrong");

   cond_target_a: assert property ( // [RULE7]
      issue_i && kind == K_BC && bc_pass && instr_i[1]
      |=> taken_o && nia_o == {{16{$past(instr_i[15])}}, $past(instr_i[15:2]), 2'b00})
      else $error("absolute conditional target wrong");

   count_zero_a: assert property ( // [RULE9]
      issue_i && kind == K_BC && bo == 5'h12
      |=> taken_o == ($past(st_q.counter) == 32'h0000_0001))
      else $error("branch on counter zero decided wrongly");

   illegal_set_a: assert property (
      issue_i && kind == K_ILL |=> illegal_o && !wr_en_o && !taken_o)
      else $error("unknown opcode not flagged");

   ack_pulse_a: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("bus acknowledge longer than one cycle");

endmodule : and_branch_exec_unit
`default_nettype wire

// ==== and_branch_defines.svh ====
// Constants of the AND and branch execution unit: opcodes, field positions,
// register offsets and reset values.
// Assumes instructions arrive with instruction bit 0 in bit 31 of the word.
`ifndef AND_BRANCH_DEFINES_SVH
`define AND_BRANCH_DEFINES_SVH

// Primary and extended opcodes.
`define OP_LOGIC_EXT      6'h1F
`define OP_AND_IMM        6'h1C
`define OP_AND_IMM_SHIFT  6'h1D
`define OP_COND_BRANCH    6'h10
`define OP_UNCOND_BRANCH  6'h12
`define XO_AND            10'h01C
`define XO_AND_COMPL      10'h03C

// Instruction field positions, little-endian bit numbers.
`define F_OPCODE_HI       31
`define F_OPCODE_LO       26
`define F_SRC_HI          25
`define F_SRC_LO          21
`define F_DEST_HI         20
`define F_DEST_LO         16
`define F_OPB_HI          15
`define F_OPB_LO          11
`define F_XO_HI           10
`define F_XO_LO           1
`define F_RECORD          0
`define F_ABSOLUTE        1
`define F_LINK            0

// Branch option field bits, little-endian inside the 5-bit field.
`define BO_IGNORE_COND    4
`define BO_COND_SENSE     3
`define BO_NO_DECR        2
`define BO_CTR_ZERO       1

// Condition register bits of the first field and the summary flag.
`define CR_NEG_BIT        31
`define CR_POS_BIT        30
`define CR_ZERO_BIT       29
`define CR_SUMMARY_BIT    28
`define XER_SUMMARY_BIT   31

// Register byte offsets on the bus and status bits.
`define ADR_COND          8'h00
`define ADR_RETURN        8'h04
`define ADR_COUNTER       8'h08
`define ADR_EXCEPTION     8'h0C
`define ADR_STATUS        8'h10
`define ST_TAKEN_BIT      0
`define ST_ILLEGAL_BIT    1

`define SEQ_STEP          32'h0000_0004
`define RESET_WORD        32'h0000_0000

`endif

// ==== and_branch_pkg.sv ====
// Types shared by the AND and branch execution unit.
// Assumes and_branch_defines.svh is compiled alongside.
`default_nettype none
package and_branch_pkg;

   typedef enum logic [6:0] {
      K_AND    = 7'b000_0001,
      K_ANDC   = 7'b000_0010,
      K_ANDI   = 7'b000_0100,
      K_ANDIS  = 7'b000_1000,
      K_BR     = 7'b001_0000,
      K_BC     = 7'b010_0000,
      K_ILL    = 7'b100_0000
   } inst_kind_t;

   typedef struct packed {
      logic [31:0] cond;
      logic [31:0] ret_addr;
      logic [31:0] counter;
      logic [31:0] exception;
      logic [31:0] nia;
      logic [31:0] wr_data;
      logic [31:0] rd_data;
      logic [4:0]  wr_idx;
      logic        wr_en;
      logic        done;
      logic        taken;
      logic        illegal;
      logic        ack;
   } exec_state_t;

endpackage : and_branch_pkg
`default_nettype wire

// ==== branch_cond_eval.sv ====
// Branch condition evaluation: loop counter decrement and condition test.
// Assumes the caller has already picked the tested condition bit.
`timescale 1ns/1ns
`default_nettype none
`include "and_branch_defines.svh"

module branch_cond_eval (
   input  wire logic [4:0]  bo_i,
   input  wire logic        cond_bit_i,
   input  wire logic [31:0] ctr_i,
   output logic      [31:0] ctr_next_o,
   output logic             pass_o
);
   logic [31:0] ctr_dec;
   logic        ctr_ok;
   logic        cond_ok;

   always_comb begin
      ctr_dec    = ctr_i - 32'h0000_0001;
      // A clear no-decrement bit counts down; the counter test uses the new value.
      ctr_next_o = bo_i[`BO_NO_DECR] ? ctr_i : ctr_dec; // [RULE9] [RULE12]
      ctr_ok     = bo_i[`BO_NO_DECR]
                 | ((ctr_dec != 32'h0000_0000) ^ bo_i[`BO_CTR_ZERO]); // [RULE9] [RULE10] [RULE11]
      cond_ok    = bo_i[`BO_IGNORE_COND] | (cond_bit_i == bo_i[`BO_COND_SENSE]); // [RULE15]
      pass_o     = ctr_ok & cond_ok; // [RULE10] [RULE11] [RULE12]
   end

endmodule : branch_cond_eval
`default_nettype wire

// ==== seq_model.sv ====
// Sequencer model: presents one instruction with its operands per call.
// Assumes the execution unit takes the word at the next rising edge.
`timescale 1ns/1ns
`default_nettype none
module seq_model (
   input  wire logic        clk_i,
   output logic             issue_o,
   output logic      [31:0] instr_o,
   output logic      [31:0] cia_o,
   output logic      [31:0] src_o,
   output logic      [31:0] opb_o
);
   initial begin
      issue_o = 1'b0;
      instr_o = 32'h0;
      cia_o = 32'h0;
      src_o = 32'h0;
      opb_o = 32'h0;
   end

   // Released lines carry the inverse of the last word, so a stale value
   // is never mistaken for a fresh one.
   task automatic send(input logic [31:0] ins, ca, s, b);
      @(posedge clk_i);
      issue_o <= 1'b1;
      instr_o <= ins;
      cia_o <= ca;
      src_o <= s;
      opb_o <= b;
      @(posedge clk_i);
      issue_o <= 1'b0;
      instr_o <= ~ins;
      cia_o <= ~ca;
      src_o <= ~s;
      opb_o <= ~b;
      #1;
   endtask : send
endmodule : seq_model
`default_nettype wire

// ==== and_branch_exec_unit_test.sv ====
// Self-checking bench for the AND and branch execution unit.
// Assumes seq_model drives the issue port and the bench is the bus master.
`timescale 1ns/1ns
`default_nettype none
module and_branch_exec_unit_test;
   typedef struct {
      logic [31:0] ins, src, opb, nia;
      logic        tk, we;
      logic [31:0] wd;
      logic [3:0]  cr;
      logic [31:0] ctr;
   } row_t;
   logic        clk_i, rst_i, issue, cyc, stb, we, done, taken, ill, wr_en, ack;
   logic [31:0] instr, cia, src, opb, nia, wr_data, adr, wdat, rdat, rd;
   logic [4:0]  wr_idx;
   logic [3:0]  sel;
   int          n_errors = 0;
   int          tests_run = 0;
   // Rows run in order, so condition and counter state carries over.
   row_t rows [14] = '{
      '{32'h7C22_1879, 32'hFFFF_FFFF, 32'hFFFF, 32'h104, 0, 1, 32'hFFFF_0000, 9, 2},
      '{32'h7C22_1838, 32'hF0F0_1234, 32'hFF00_00FF, 32'h104, 0, 1, 32'hF000_0034, 9, 2},
      '{32'h7022_ABCD, 32'h1234_5678, 32'h0, 32'h104, 0, 1, 32'h248, 5, 2},
      '{32'h7422_0000, 32'h1234_5678, 32'h0, 32'h104, 0, 1, 32'h0, 3, 2},
      '{32'h4182_0010, 32'h0, 32'h0, 32'h110, 1, 0, 32'h0, 3, 2},
      '{32'h4082_0010, 32'h0, 32'h0, 32'h104, 0, 0, 32'h0, 3, 2},
      '{32'h4200_FFFD, 32'h0, 32'h0, 32'hFC, 1, 0, 32'h0, 3, 1},
      '{32'h4240_0082, 32'h0, 32'h0, 32'h80, 1, 0, 32'h0, 3, 0},
      '{32'h4000_0010, 32'h0, 32'h0, 32'h110, 1, 0, 32'h0, 3, 32'hFFFF_FFFF},
      '{32'h4102_0010, 32'h0, 32'h0, 32'h110, 1, 0, 32'h0, 3, 32'hFFFF_FFFE},
      '{32'h4040_0010, 32'h0, 32'h0, 32'h104, 0, 0, 32'h0, 3, 32'hFFFF_FFFD},
      '{32'h4BFF_FFF9, 32'h0, 32'h0, 32'hF8, 1, 0, 32'h0, 3, 32'hFFFF_FFFD},
      '{32'h4800_0102, 32'h0, 32'h0, 32'h100, 1, 0, 32'h0, 3, 32'hFFFF_FFFD},
      '{32'h0, 32'h0, 32'h0, 32'h104, 0, 0, 32'h0, 3, 32'hFFFF_FFFD}
   };

   seq_model seq (.clk_i(clk_i), .issue_o(issue), .instr_o(instr), .cia_o(cia),
                  .src_o(src), .opb_o(opb));

   and_branch_exec_unit dut (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .issue_i    (issue),
      .instr_i    (instr),
      .cia_i      (cia),
      .src_data_i (src),
      .opb_data_i (opb),
      .done_o     (done),
      .taken_o    (taken),
      .illegal_o  (ill),
      .nia_o      (nia),
      .wr_en_o    (wr_en),
      .wr_idx_o   (wr_idx),
      .wr_data_o  (wr_data),
      .wb_cyc_i   (cyc),
      .wb_stb_i   (stb),
      .wb_we_i    (we),
      .wb_adr_i   (adr),
      .wb_sel_i   (sel),
      .wb_dat_i   (wdat),
      .wb_dat_o   (rdat),
      .wb_ack_o   (ack)
   );

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic chk(input string what, input logic [31:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One classic cycle; the request stands until ack is sampled high.
   task automatic bus(input logic w, input logic [31:0] a, d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) chk("ack", 1, ack);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus

   task automatic run(input row_t r);
      seq.send(r.ins, 32'h100, r.src, r.opb);
      chk("done", 1, done);
      chk("nia", r.nia, nia);
      chk("taken", r.tk, taken);
      chk("wr_en", r.we, wr_en);
      if (r.we) begin
         chk("wr_data", r.wd, wr_data);
         chk("wr_idx", 2, wr_idx);
      end
      bus(0, 32'h0, 32'h0, 4'hF);
      chk("cond", r.cr, rd[31:28]);
      bus(0, 32'h8, 32'h0, 4'hF);
      chk("counter", r.ctr, rd);
   endtask : run

   task automatic conclude();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude

   initial begin
      #100000;
      n_errors++;
      conclude();
   end

   initial begin
      rst_i = 1'b1;
      {cyc, stb, we, sel, adr, wdat} = '0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a <= 20; a += 4) begin
         bus(0, 32'(a), 32'h0, 4'hF);
         chk("reset value", 0, rd);
      end
      $display("test reset done");
      bus(1, 32'hC, 32'h8000_0000, 4'hF);
      bus(1, 32'h8, 32'h2, 4'hF);
      foreach (rows[i]) run(rows[i]);
      bus(0, 32'h4, 32'h0, 4'hF);
      chk("return link", 32'h104, rd);
      $display("test table done");
      chk("illegal", 1, ill);
      bus(0, 32'h10, 32'h0, 4'hF);
      chk("status", 32'h2, rd);
      bus(1, 32'h10, 32'h2, 4'h1);
      bus(0, 32'h10, 32'h0, 4'hF);
      chk("status", 32'h0, rd);
      $display("test status done");
      bus(1, 32'h4, 32'hDEC, 4'hF);
      bus(1, 32'h8, 32'h1, 4'hF);
      seq.send(32'h4142_0010, 32'h100, 32'h0, 32'h0);
      chk("taken", 1, taken);
      chk("nia", 32'h110, nia);
      bus(0, 32'h8, 32'h0, 4'hF);
      chk("counter", 0, rd);
      bus(0, 32'h4, 32'h0, 4'hF);
      chk("return", 32'hDEC, rd);
      bus(1, 32'h8, 32'hFFFF_FFFF, 4'h1);
      bus(0, 32'h8, 32'h0, 4'hF);
      chk("counter lane", 32'hFF, rd);
      bus(1, 32'h0, 32'h4000_0000, 4'hF);
      seq.send(32'h4181_0008, 32'h100, 32'h0, 32'h0);
      chk("taken", 1, taken);
      chk("nia", 32'h108, nia);
      $display("test count zero done");
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(0, 32'h4, 32'h0, 4'hF);
      chk("return after reset", 0, rd);
      $display("test second reset done");
      conclude();
   end
endmodule : and_branch_exec_unit_test
`default_nettype wire
